// >>> rtl/btrm_core.v
// Termination control of a two-bus bridge with an AHB-Lite register slave.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "btrm_map.vh"
// Contract
// R1: posted retry repeats the same address
// R2: posted disconnect resumes at next dword
// R3: resumed invalidate write uses plain write
// R4: posted abort sets status, raises serr
// R5: posted drop after limit, gated serr
// R6: delayed read disconnect per prefetch rules
// R7: delayed read retry restarts the read
// R8: short delayed read returns disconnect
// R9: delayed read abort forwarded with status
// R10: repeat read until data or abort
// R11: exhausted read dropped, serr, then abort
// R12: delayed write retry conditions
// R13: delayed read retry conditions
// R14: posted write retry conditions
// R15: initiator repeats retried request in time
// R16: unrepeated delayed request dropped on timeout
// R17: disconnect at boundary or end
// R18: abort on forwarded abort or exhaustion
// R19: signaled abort sets initiator side bit
// R20: master abort after five cycles
// R21: master abort gives ones or abort
// R22: per transaction 24 bit retry count; the counters here are 25 bits wide
module btrm_core #(
  parameter TRIES = `BTRM_TRIES,   // Retry limit per transaction.
  parameter MTO   = `BTRM_MTO      // Initiator repeat timeout, cycles.
) (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Initiator side request.
  input  wire        i_req,
  input  wire        i_write,
  input  wire        i_posted,
  input  wire        i_locked,
  input  wire        i_dir,
  input  wire [31:0] i_addr,
  input  wire [3:0]  i_cmd,
  input  wire [3:0]  i_len,
  input  wire        i_pref,
  input  wire        i_more,
  input  wire        i_bound,
  // Initiator side conditions.
  input  wire        q_full,
  input  wire        lock_act,
  input  wire        pw_room,
  input  wire        dw_busy,
  input  wire        dw_dup,
  input  wire        dw_exh,
  input  wire        rd_behind,
  input  wire        rd_drop,
  // Initiator side answer.
  output reg         i_rsp_v,
  output reg  [2:0]  i_rsp,
  output reg         i_disc,
  // Target side master engine.
  output reg         m_start,
  output reg         m_write,
  output reg  [31:0] m_addr,
  output reg  [3:0]  m_cmd,
  input  wire        m_devsel,
  input  wire        m_done,
  input  wire [1:0]  m_term,
  input  wire [3:0]  m_xfer,
  output reg         m_abort,
  // System error pulse.
  output reg         serr
);
  // ============================================
  // Master state machine, one-hot.
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_ADDR = 3'b010;
  localparam [2:0] S_DATA = 3'b100;
  reg  [2:0]  st_r;          // Master state.
  reg  [2:0]  ma_cnt_r;      // Cycles waiting for a claim.
  reg         cur_pw_r;      // Running attempt is the posted write.
  // Posted write slot.
  reg         pw_v_r;        // Slot holds data.
  reg  [31:0] pw_addr_r;     // Address of next dword.
  reg         pw_mwi_r;      // Invalidate command still allowed.
  reg  [3:0]  pw_left_r;     // Dwords not yet delivered.
  reg  [24:0] pw_cnt_r;      // Retry count.
  reg         pw_dir_r;      // Initiator side of the write.
  // Delayed read slot.
  reg         dr_v_r;        // Slot in use.
  reg         dr_ok_r;       // Result is ready.
  reg  [31:0] dr_addr_r;     // Request address.
  reg  [3:0]  dr_cmd_r;      // Request command.
  reg         dr_pref_r;     // Prefetchable read.
  reg         dr_dir_r;      // Initiator side of the read.
  reg  [1:0]  dr_res_r;      // Result kind.
  reg  [24:0] dr_cnt_r;      // Retry count.
  reg  [15:0] dr_tmo_r;      // Cycles since last repeat.
  // Registers.
  reg  [`BTRM_CW-1:0] ctrl_r; // Control bits.
  reg  [`BTRM_SW-1:0] stat_r; // Sticky status.
  reg  [7:0]  a_addr_r;      // Latched bus address.
  reg         a_wr_r;        // Write data phase pending.
  // ============================================
  // Event decode. Side 0 is primary, 1 secondary.
  wire [1:0] tside = cur_pw_r ? {~pw_dir_r, pw_dir_r}
                              : {~dr_dir_r, dr_dir_r};
  wire done  = st_r[2] & m_done;
  wire m_ma  = st_r[1] & ~m_devsel & (ma_cnt_r == `BTRM_MA_CYC);
  wire rtry  = done & (m_term == `BTRM_T_RTRY
             | (m_term == `BTRM_T_DISC & m_xfer == 4'h0));
  wire tabt  = done & m_term == `BTRM_T_TABT;
  wire good  = done & ~rtry & ~tabt;
  wire [24:0] pw_cnt_nxt = pw_cnt_r + 25'h1;
  wire [24:0] dr_cnt_nxt = dr_cnt_r + 25'h1;
  wire [24:0] lim = TRIES[24:0];
  wire pw_exh = cur_pw_r & rtry & pw_cnt_nxt == lim;
  wire dr_exh = ~cur_pw_r & rtry & dr_cnt_nxt == lim;
  wire [3:0] pw_left_nxt = pw_left_r - m_xfer;
  wire dr_hit = dr_v_r & i_addr == dr_addr_r
                & i_cmd == dr_cmd_r;
  wire rd_req = i_req & ~i_write;
  wire lk_bad = lock_act & ~i_locked;
  wire dr_take = rd_req & dr_hit & dr_ok_r & ~lk_bad
                 & ~rd_drop & ~rd_behind & ~pw_v_r;
  wire pw_take = i_req & i_write & i_posted & ~lk_bad
                 & pw_room & ~pw_v_r;
  wire dr_load = rd_req & ~dr_v_r & ~q_full & ~lk_bad
                 & ~rd_drop;
  wire dr_tmo = dr_ok_r & dr_tmo_r == MTO[15:0] - 16'h1;
  wire en = ctrl_r[`BTRM_C_SERR];
  // System error causes, all gated by the enable bit; all but the posted abort also by their own disable bit.
  wire serr_ev = en & ((cur_pw_r & tabt)                         // [R4]
               | (pw_exh & ~ctrl_r[`BTRM_C_DPWX])                // [R5]
               | (dr_exh & ~ctrl_r[`BTRM_C_DDRX])                // [R11]
               | (cur_pw_r & m_ma & ctrl_r[`BTRM_C_MAM]
                  & ~ctrl_r[`BTRM_C_DPMA]));
  // ============================================
  // Initiator answer, decided in the request cycle.
  reg  [2:0] rsp;
  reg        dsc;
  reg  [1:0] sig_set;
  always @* begin
    rsp     = `BTRM_R_RTRY;
    dsc     = 1'b0;
    sig_set = 2'h0;
    if (i_write & i_posted) begin
      if (pw_take) begin
        rsp = `BTRM_R_ACC;
        dsc = i_bound;                                           // [R17]
      end
      // Otherwise no room or a foreign lock: retry.           [R14]
    end else if (i_write) begin
      // Queued, busy, full, duplicate or locked out: retry.   [R12]
      if (dw_exh & ~dw_busy) begin
        rsp = `BTRM_R_TABT;                                      // [R18]
        sig_set[i_dir] = 1'b1;                                   // [R19]
      end
    end else if (dr_take) begin
      case (dr_res_r)
        `BTRM_D_DATA: begin
          rsp = `BTRM_R_DATA;
          dsc = ~dr_pref_r | i_more | i_bound;                   // [R6] [R8] [R17]
        end
        `BTRM_D_MA: begin
          if (ctrl_r[`BTRM_C_MAM]) begin
            rsp = `BTRM_R_TABT;                                  // [R21]
            sig_set[dr_dir_r] = 1'b1;
          end else begin
            rsp = `BTRM_R_ONES;                                  // [R21]
          end
        end
        default: begin
          rsp = `BTRM_R_TABT;                                    // [R9] [R11] [R18]
          sig_set[dr_dir_r] = 1'b1;                              // [R19]
        end
      endcase
    end
    // Every other read case stays a retry.                    [R13]
  end
  // ============================================
  // Answer registers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_rsp_v <= 1'b0;
      i_rsp   <= `BTRM_R_ACC;
      i_disc  <= 1'b0;
    end else begin
      i_rsp_v <= i_req;
      i_rsp   <= rsp;
      i_disc  <= dsc;
    end
  end
  // ============================================
  // Master sequencer: posted writes go first so that
  // read data never passes older write data.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= S_IDLE;
      ma_cnt_r <= 3'h0;
      cur_pw_r <= 1'b0;
      m_start  <= 1'b0;
      m_write  <= 1'b0;
      m_addr   <= 32'h0;
      m_cmd    <= 4'h0;
      m_abort  <= 1'b0;
    end else begin
      m_start <= 1'b0;
      m_abort <= 1'b0;
      case (st_r)
        S_IDLE: begin
          ma_cnt_r <= 3'h0;
          if (pw_v_r & ~pw_take) begin
            st_r     <= S_ADDR;
            cur_pw_r <= 1'b1;
            m_start  <= 1'b1;
            m_write  <= 1'b1;
            m_addr   <= pw_addr_r;                               // [R1] [R2]
            m_cmd    <= pw_mwi_r ? `BTRM_CMD_MWI : `BTRM_CMD_MW; // [R3]
          end else if (dr_v_r & ~dr_ok_r) begin
            st_r     <= S_ADDR;                                  // [R7] [R10]
            cur_pw_r <= 1'b0;
            m_start  <= 1'b1;
            m_write  <= 1'b0;
            m_addr   <= dr_addr_r;
            m_cmd    <= dr_cmd_r;
          end
        end
        S_ADDR: begin
          if (m_devsel) begin
            st_r <= S_DATA;
          end else if (m_ma) begin
            st_r    <= S_IDLE;                                   // [R20]
            m_abort <= 1'b1;
          end else begin
            ma_cnt_r <= ma_cnt_r + 3'h1;
          end
        end
        S_DATA: begin
          if (m_done) begin
            st_r <= S_IDLE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
  // ============================================
  // Posted write slot.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_v_r    <= 1'b0;
      pw_addr_r <= 32'h0;
      pw_mwi_r  <= 1'b0;
      pw_left_r <= 4'h0;
      pw_cnt_r  <= 25'h0;
      pw_dir_r  <= 1'b0;
    end else if (pw_take) begin
      pw_v_r    <= 1'b1;
      pw_addr_r <= i_addr;
      pw_mwi_r  <= i_cmd == `BTRM_CMD_MWI;
      pw_left_r <= i_len;
      pw_cnt_r  <= 25'h0;                                        // [R22]
      pw_dir_r  <= i_dir;
    end else if (cur_pw_r) begin
      if (m_ma | tabt | pw_exh) begin
        pw_v_r <= 1'b0;                                          // [R4] [R5]
      end else if (rtry) begin
        pw_cnt_r <= pw_cnt_nxt;                                  // [R22]
      end else if (good) begin
        // Resume at the first undelivered dword.
        pw_addr_r <= pw_addr_r + {26'h0, m_xfer, 2'h0};          // [R2]
        pw_left_r <= pw_left_nxt;
        pw_mwi_r  <= 1'b0;                                       // [R3]
        pw_v_r    <= pw_left_nxt != 4'h0;
      end
    end
  end
  // ============================================
  // Delayed read slot. A result waits for the initiator to
  // come back; if it does not, the slot is freed.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_v_r    <= 1'b0;
      dr_ok_r   <= 1'b0;
      dr_addr_r <= 32'h0;
      dr_cmd_r  <= 4'h0;
      dr_pref_r <= 1'b0;
      dr_dir_r  <= 1'b0;
      dr_res_r  <= `BTRM_D_DATA;
      dr_cnt_r  <= 25'h0;
      dr_tmo_r  <= 16'h0;
    end else if (dr_take | dr_tmo) begin
      dr_v_r  <= 1'b0;                                           // [R16]
      dr_ok_r <= 1'b0;
    end else if (dr_load) begin
      dr_v_r    <= 1'b1;
      dr_ok_r   <= 1'b0;
      dr_addr_r <= i_addr;
      dr_cmd_r  <= i_cmd;
      dr_pref_r <= i_pref;
      dr_dir_r  <= i_dir;
      dr_cnt_r  <= 25'h0;                                        // [R22]
      dr_tmo_r  <= 16'h0;
    end else begin
      if (rd_req & dr_hit) begin
        dr_tmo_r <= 16'h0;                                       // [R15]
      end else if (dr_ok_r) begin
        dr_tmo_r <= dr_tmo_r + 16'h1;
      end
      if (~cur_pw_r & (m_ma | done)) begin
        if (rtry & ~dr_exh) begin
          dr_cnt_r <= dr_cnt_nxt;                                // [R7] [R22]
        end else begin
          dr_ok_r  <= 1'b1;                                      // [R10]
          dr_res_r <= m_ma ? `BTRM_D_MA
                    : tabt ? `BTRM_D_TA
                    : dr_exh ? `BTRM_D_EXH : `BTRM_D_DATA;       // [R11]
        end
      end
    end
  end
  // ============================================
  // Status bits: hardware set wins over software clear.
  wire [1:0] rta = tabt ? tside : 2'h0;
  wire [1:0] rma = m_ma ? tside : 2'h0;
  wire [`BTRM_SW-1:0] st_set;
  assign st_set = {serr_ev | (cur_pw_r & tabt), rma, rta, sig_set}; // [R4] [R9]
  wire st_clr = a_wr_r & a_addr_r == `BTRM_STAT;
  genvar g;
  generate
    for (g = 0; g < `BTRM_SW; g = g + 1) begin : g_st
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stat_r[g] <= 1'b0;
        end else if (st_set[g]) begin
          stat_r[g] <= 1'b1;                                     // [R19]
        end else if (st_clr & hwdata[g]) begin
          stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // ============================================
  // System error pulse.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serr <= 1'b0;
    end else begin
      serr <= serr_ev;                                           // [R5] [R11]
    end
  end
  // ============================================
  // AHB-Lite slave: zero wait, always OKAY. Read data is
  // prepared in the address phase so it leaves a flop.
  wire a_go = hsel & htrans[1] & hready;
  reg  [31:0] rd_mux;
  always @* begin
    case (haddr[7:0])
      `BTRM_CTRL: rd_mux = {{(32-`BTRM_CW){1'b0}}, ctrl_r};
      `BTRM_STAT: rd_mux = {{(32-`BTRM_SW){1'b0}}, stat_r};
      `BTRM_SLOT: rd_mux = {28'h0, dr_ok_r, dr_v_r, cur_pw_r, pw_v_r};
      default:    rd_mux = 32'h0;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr_r  <= 8'h0;
      a_wr_r    <= 1'b0;
      ctrl_r    <= {`BTRM_CW{1'b0}};
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (a_wr_r & a_addr_r == `BTRM_CTRL) begin
        ctrl_r <= hwdata[`BTRM_CW-1:0];
      end
      if (hready) begin
        a_wr_r   <= a_go & hwrite;
        a_addr_r <= haddr[7:0];
        if (a_go & ~hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end
endmodule // btrm_core

// >>> rtl/btrm_map.vh
// Offsets, fields, codes and counts of the bridge termination block.
`ifndef BTRM_MAP_VH
`define BTRM_MAP_VH
// ============================================
// Register byte offsets.
`define BTRM_CTRL 8'h00
`define BTRM_STAT 8'h04
`define BTRM_SLOT 8'h08
// ============================================
// Control bit positions.
`define BTRM_C_SERR 0
`define BTRM_C_MAM 1
`define BTRM_C_DPWX 2
`define BTRM_C_DDRX 3
`define BTRM_C_DPMA 4
`define BTRM_CW 5
// ============================================
// Status bit positions (write one to clear).
`define BTRM_S_SIGTA 0
`define BTRM_S_RCVTA 2
`define BTRM_S_RCVMA 4
`define BTRM_S_SERR 6
`define BTRM_SW 7
// ============================================
// Target termination codes from the master engine.
`define BTRM_T_NORM 2'h0
`define BTRM_T_RTRY 2'h1
`define BTRM_T_DISC 2'h2
`define BTRM_T_TABT 2'h3
// ============================================
// Answers to the initiator.
`define BTRM_R_ACC 3'h0
`define BTRM_R_RTRY 3'h1
`define BTRM_R_DATA 3'h2
`define BTRM_R_TABT 3'h3
`define BTRM_R_ONES 3'h4
// ============================================
// Delayed read results.
`define BTRM_D_DATA 2'h0
`define BTRM_D_TA 2'h1
`define BTRM_D_MA 2'h2
`define BTRM_D_EXH 2'h3
// ============================================
// Bus commands and timing.
`define BTRM_CMD_MW 4'h7
`define BTRM_CMD_MWI 4'hf
`define BTRM_MA_CYC 3'h5
`define BTRM_TRIES 16777216
`define BTRM_MTO 32768
`endif

// >>> test/btrm_core_asserts.sv
// Port checks of the bridge termination block.
`timescale 1ns/10ps
`include "btrm_map.vh"
module btrm_core_asserts (
  // Clock, reset, bus answer.
  input wire        hclk,
  input wire        hresetn,
  input wire        hreadyout,
  input wire        hresp,
  // Initiator side.
  input wire        i_req,
  input wire        i_write,
  input wire        i_posted,
  input wire        i_locked,
  input wire        lock_act,
  input wire        pw_room,
  input wire        dw_busy,
  input wire        dw_exh,
  input wire        i_rsp_v,
  input wire [2:0]  i_rsp,
  // Target side.
  input wire        m_start,
  input wire        m_write,
  input wire [1:0]  m_term,
  input wire [31:0] m_addr,
  input wire [3:0]  m_cmd,
  input wire        m_devsel,
  input wire        m_done,
  input wire        m_abort
);
  // ==========
  // One domain, so clock and reset are given once.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rsp; i_req |=> i_rsp_v; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_cause; i_rsp_v |-> $past(i_req); endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_lock; i_req && lock_act && !i_locked |=> i_rsp == `BTRM_R_RTRY; endproperty
  a_lock: assert property (p_lock) else $error("lock not retried");
  property p_room; i_req && i_write && i_posted && !pw_room |=> i_rsp == `BTRM_R_RTRY;
  endproperty
  a_room: assert property (p_room) else $error("full buffer not retried");
  property p_dw;
    i_req && i_write && !i_posted && !(dw_exh && !dw_busy) |=> i_rsp == `BTRM_R_RTRY;
  endproperty
  a_dw: assert property (p_dw) else $error("delayed write not retried");
  // A retried attempt must come back with address and command untouched.
  // The restart of the same kind of transfer is the one that is compared.
  property p_same;
    (m_done && m_term == `BTRM_T_RTRY) ##[1:4] (m_start && $stable(m_write))
      |-> $stable(m_addr) && $stable(m_cmd);
  endproperty
  a_same: assert property (p_same) else $error("retry moved address");
  property p_ma; m_start ##1 !m_devsel [*5] |-> ##[0:2] m_abort; endproperty
  a_ma: assert property (p_ma) else $error("no master abort");
  property p_claim; m_start ##1 m_devsel |-> !m_abort [*6]; endproperty
  a_claim: assert property (p_claim) else $error("abort on claimed");
  property p_gap; m_done |=> !m_start; endproperty
  a_gap: assert property (p_gap) else $error("restart too soon");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
endmodule // btrm_core_asserts
bind btrm_core btrm_core_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .i_req(i_req), .i_write(i_write), .i_posted(i_posted), .i_locked(i_locked),
  .lock_act(lock_act), .pw_room(pw_room), .dw_busy(dw_busy), .dw_exh(dw_exh),
  .i_rsp_v(i_rsp_v), .i_rsp(i_rsp), .m_start(m_start), .m_addr(m_addr),
  .m_write(m_write), .m_term(m_term),
  .m_cmd(m_cmd), .m_devsel(m_devsel), .m_done(m_done), .m_abort(m_abort)
);

// >>> test/btrm_core_tb.sv
// Self-checking bench of the bridge termination block.
`timescale 1ns/10ps
`include "btrm_map.vh"
module btrm_core_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, i_addr = 32'h0, rd;
  logic [1:0]  htrans = 2'h0, t_term = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        i_req = 1'b0, i_write = 1'b0, i_posted = 1'b0, i_locked = 1'b0, i_dir = 1'b0;
  logic [3:0]  i_cmd = 4'h0, t_xfer = 4'h1;
  logic        q_full = 1'b0, lock_act = 1'b0, pw_room = 1'b1, dw_busy = 1'b0;
  logic        dw_dup = 1'b0, t_claim = 1'b1;
  logic        i_pref = 1'b0, i_more = 1'b0, i_bound = 1'b0, dw_exh = 1'b0, e_disc = 1'b1;
  wire  [31:0] hrdata, m_addr;
  wire         hreadyout, hresp, i_rsp_v, i_disc, m_start, m_write, m_abort, serr;
  wire         m_devsel, m_done;
  wire  [2:0]  i_rsp;
  wire  [3:0]  m_cmd, m_xfer;
  wire  [1:0]  m_term;
  int          n_mismatch = 0, num_checks = 0;
  // ==========
  // Short retry limit and repeat timeout keep the run brief.
  btrm_core #(.TRIES(4), .MTO(20)) i_btrm_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .i_req(i_req),
    .i_write(i_write), .i_posted(i_posted), .i_locked(i_locked), .i_dir(i_dir),
    .i_addr(i_addr), .i_cmd(i_cmd), .i_len(4'h4), .i_pref(i_pref), .i_more(i_more),
    .i_bound(i_bound), .q_full(q_full), .lock_act(lock_act), .pw_room(pw_room),
    .dw_busy(dw_busy), .dw_dup(dw_dup), .dw_exh(dw_exh), .rd_behind(1'b0),
    .rd_drop(1'b0), .i_rsp_v(i_rsp_v), .i_rsp(i_rsp), .i_disc(i_disc),
    .m_start(m_start), .m_write(m_write), .m_addr(m_addr), .m_cmd(m_cmd),
    .m_devsel(m_devsel), .m_done(m_done), .m_term(m_term), .m_xfer(m_xfer),
    .m_abort(m_abort), .serr(serr));
  btrm_tgt_model i_btrm_tgt_model (
    .hclk(hclk), .hresetn(hresetn), .t_claim(t_claim), .t_term(t_term),
    .t_xfer(t_xfer), .m_start(m_start), .m_devsel(m_devsel), .m_done(m_done),
    .m_term(m_term), .m_xfer(m_xfer));
  always #2.5 hclk = ~hclk;
  // ==========
  // Shared tasks.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Single word transfer; hready is the slave's own hreadyout.
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e, "register");
  endtask
  // One initiator request; the answer stands one cycle and is read at the edge ending it.
  task req(input logic w, input logic p, input logic [31:0] a, input logic [3:0] c,
           input logic [2:0] er);
    @(posedge hclk);
    i_req <= 1'b1;
    i_write <= w;
    i_posted <= p;
    i_addr <= a;
    i_cmd <= c;
    @(posedge hclk);
    i_req <= 1'b0;
    @(posedge hclk);
    chk(i_rsp_v, 1, "answer valid");
    chk(i_rsp, er, "answer code");
    if (er == `BTRM_R_DATA) chk(i_disc, e_disc, "disconnect");
    if (er == `BTRM_R_ACC) chk(i_disc, i_bound, "disconnect");
  endtask
  // Waits for start (0), master abort (1) or system error (2).
  task wt(input int s);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (k < 20 && (s == 0 ? m_start : s == 1 ? m_abort : serr) !== 1'b1);
    if (k == 20) chk(0, 1, "wait");
  endtask
  task att(input logic [1:0] tm, input logic [3:0] x, input logic [31:0] a,
           input logic [3:0] c);
    wt(0);
    chk(m_addr, a, "attempt address");
    chk(m_cmd, c, "attempt command");
    t_term <= tm;
    t_xfer <= x;
  endtask
  // ==========
  // Scenarios.
  task t_regs;
    rchk(`BTRM_CTRL, 32'hff, 0);
    rchk(`BTRM_STAT, 32'hff, 0);
    rchk(`BTRM_SLOT, 32'hff, 0);
    ahb(1'b1, `BTRM_CTRL, 32'h1f);
    rchk(`BTRM_CTRL, 32'hff, 32'h1f);
    rchk(32'h0c, 32'hffffffff, 0);
    ahb(1'b1, `BTRM_CTRL, 32'h01);
    $display("register test done");
  endtask
  task t_posted;
    req(1, 1, 32'h1000, `BTRM_CMD_MWI, `BTRM_R_ACC);
    att(`BTRM_T_RTRY, 0, 32'h1000, `BTRM_CMD_MWI);
    att(`BTRM_T_DISC, 2, 32'h1000, `BTRM_CMD_MWI);
    att(`BTRM_T_NORM, 2, 32'h1008, `BTRM_CMD_MW);
    repeat (4) @(posedge hclk);
    rchk(`BTRM_SLOT, 32'h1, 0);
    i_bound <= 1'b1;
    req(1, 1, 32'h3000, `BTRM_CMD_MW, `BTRM_R_ACC);
    i_bound <= 1'b0;
    att(`BTRM_T_TABT, 0, 32'h3000, `BTRM_CMD_MW);
    wt(2);
    rchk(`BTRM_STAT, 32'h7f, 32'h48);
    ahb(1'b1, `BTRM_STAT, 32'h7f);
    rchk(`BTRM_STAT, 32'h7f, 0);
    $display("posted write test done");
  endtask
  task t_dread;
    i_pref <= 1'b1;
    req(0, 0, 32'h2000, 4'h6, `BTRM_R_RTRY);
    att(`BTRM_T_RTRY, 0, 32'h2000, 4'h6);
    req(0, 0, 32'h2000, 4'h6, `BTRM_R_RTRY);
    att(`BTRM_T_DISC, 1, 32'h2000, 4'h6);
    repeat (6) @(posedge hclk);
    i_more <= 1'b1;
    req(0, 0, 32'h2000, 4'h6, `BTRM_R_DATA);
    i_pref <= 1'b0;
    i_more <= 1'b0;
    i_dir <= 1'b1;
    req(0, 0, 32'h4000, 4'h6, `BTRM_R_RTRY);
    att(`BTRM_T_TABT, 0, 32'h4000, 4'h6);
    repeat (6) @(posedge hclk);
    req(0, 0, 32'h4000, 4'h6, `BTRM_R_TABT);
    rchk(`BTRM_STAT, 32'h0f, 32'h06);
    ahb(1'b1, `BTRM_STAT, 32'h7f);
    i_dir <= 1'b0;
    $display("delayed read test done");
  endtask
  task t_mabt;
    t_claim <= 1'b0;
    req(0, 0, 32'h5000, 4'h6, `BTRM_R_RTRY);
    wt(1);
    t_claim <= 1'b1;
    repeat (4) @(posedge hclk);
    req(0, 0, 32'h5000, 4'h6, `BTRM_R_ONES);
    rchk(`BTRM_STAT, 32'h30, 32'h20);
    ahb(1'b1, `BTRM_STAT, 32'h7f);
    $display("master abort test done");
  endtask
  task t_exh;
    req(0, 0, 32'h6000, 4'h6, `BTRM_R_RTRY);
    for (int k = 0; k < 4; k++) att(`BTRM_T_RTRY, 0, 32'h6000, 4'h6);
    wt(2);
    req(0, 0, 32'h6000, 4'h6, `BTRM_R_TABT);
    rchk(`BTRM_STAT, 32'h01, 32'h01);
    i_pref <= 1'b1;
    req(0, 0, 32'h7000, 4'h6, `BTRM_R_RTRY);
    att(`BTRM_T_NORM, 1, 32'h7000, 4'h6);
    repeat (40) @(posedge hclk);
    req(0, 0, 32'h7000, 4'h6, `BTRM_R_RTRY);
    att(`BTRM_T_NORM, 1, 32'h7000, 4'h6);
    repeat (6) @(posedge hclk);
    e_disc <= 1'b0;
    req(0, 0, 32'h7000, 4'h6, `BTRM_R_DATA);
    i_pref <= 1'b0;
    e_disc <= 1'b1;
    $display("exhaustion test done");
  endtask
  // Each pass raises one blocking condition alone.
  task t_retry;
    for (int k = 0; k < 5; k++) begin
      lock_act <= (k == 0);
      pw_room <= (k != 1);
      dw_busy <= (k == 2);
      dw_dup <= (k == 3);
      q_full <= (k == 4);
      req(k < 4, k < 2, 32'h8000, 4'h7, `BTRM_R_RTRY);
    end
    // An exhausted delayed write is aborted toward a secondary initiator.
    dw_exh <= 1'b1;
    i_dir <= 1'b1;
    req(1, 0, 32'h8000, 4'h7, `BTRM_R_TABT);
    dw_exh <= 1'b0;
    i_dir <= 1'b0;
    rchk(`BTRM_STAT, 32'h02, 32'h02);
    $display("retry condition test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_posted;
    t_dread;
    t_mabt;
    t_exh;
    t_retry;
    end_sim;
  end
  // The whole run needs a few hundred cycles; this cuts a hang.
  initial begin
    #50000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog ran out", $time);
    end_sim;
  end
endmodule // btrm_core_tb

// >>> test/btrm_tgt_model.sv
// Target on the far bus: claims, then ends each attempt as told.
`timescale 1ns/10ps
module btrm_tgt_model (
  // Clock and reset.
  input  wire       hclk,
  input  wire       hresetn,
  // Script from the bench.
  input  wire       t_claim,
  input  wire [1:0] t_term,
  input  wire [3:0] t_xfer,
  // Master engine.
  input  wire       m_start,
  output reg        m_devsel,
  output reg        m_done,
  output reg  [1:0] m_term,
  output reg  [3:0] m_xfer
);
  reg [1:0] cnt_r; // Attempt phase.
  // ==========
  // Claim right after start, end one cycle later; outside a done the
  // code lines toggle so a stale value is never mistaken for an answer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 2'h0;
      m_devsel <= 1'b0;
      m_done <= 1'b0;
      m_term <= 2'h0;
      m_xfer <= 4'h0;
    end else if (m_start && t_claim) begin
      cnt_r <= 2'h1;
      m_devsel <= 1'b1;
    end else if (cnt_r == 2'h1) begin
      cnt_r <= 2'h2;
      m_done <= 1'b1;
      m_term <= t_term;
      m_xfer <= t_xfer;
    end else begin
      cnt_r <= 2'h0;
      m_devsel <= 1'b0;
      m_done <= 1'b0;
      m_term <= ~m_term;
      m_xfer <= ~m_xfer;
    end
  end
endmodule // btrm_tgt_model
